//--- core/amc_sync.v
// ============================================================
// two-flop synchroniser for a group of pins
module amc_sync #(
    parameter W = 1
) (
    input wire core_clk,
    input wire resetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta;

    // first stage feeds only the second stage
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // amc_sync

//--- core/amc_top.v
// Operation
// - outputs held low while calibrating
// - forwarded clock keeps running during calibration
// - sixty sampling cycles of flush after calibration
// - per-channel shutdown, pin ORed with register
// - interleave: A on rise, B on fall
// - pin mode interleave uses input A only
// - register interleave bit replaces the pin
// - register input-B bit routes B to both when interleaving without dual
// - register dual-input bit drives both inputs
// - split-clock bit: separate paths, half period apart
// - 1:4 order B-del, A-del, B, A
// - non-demux interleave: B earlier, A later
// - one bus at rate, or two at half
// - bus count per channel and mode
// - demux choice only from its own pin
// - non-demux allows only DDR zero phase
// - pin mode ignores register writes
// - interleave pin high selects interleaving
// - DDR data on clock edge or midway
// - SDR phase bit picks falling or rising
// - register mode takes phase from register bit
// - select pin high restores register defaults
`include "amc_consts.vh"

module amc_top #(
    parameter DW = 12
) (
    input wire core_clk,
    input wire resetn,
    // pins from outside this clock domain
    input wire sample_clk,
    input wire extended_control_select_n,
    input wire interleave_select,
    input wire single_bus_select,
    input wire output_phase_select,
    input wire chan_a_shutdown,
    input wire chan_b_shutdown,
    input wire calibration_running,
    input wire [DW-1:0] conv_a_data,
    input wire conv_a_ovr,
    input wire [DW-1:0] conv_b_data,
    input wire conv_b_ovr,
    // sample buses and forwarded clock
    output reg [DW-1:0] bus_a_main,
    output reg [DW-1:0] bus_a_delayed,
    output reg [DW-1:0] bus_b_main,
    output reg [DW-1:0] bus_b_delayed,
    output reg ovr_a,
    output reg ovr_b,
    output reg forwarded_output_clock,
    // mode outputs toward the converter cores
    output reg chan_a_powerdown,
    output reg chan_b_powerdown,
    output reg interleave_active,
    output reg conv_a_uses_input_b,
    output reg conv_b_uses_input_b,
    output reg split_path_interleave_mode,
    // axi4-lite slave
    input wire [`AMC_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`AMC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    localparam SW = 2 * DW + 10;

    // ============================================================
    // pin synchronisation
    wire [SW-1:0] pins_s;
    wire smp_clk_s;
    wire ecm_n_s;
    wire il_pin_s;
    wire single_bus_s;
    wire phase_pin_s;
    wire pd_a_pin_s;
    wire pd_b_pin_s;
    wire cal_s;
    wire [DW-1:0] a_data_s;
    wire [DW-1:0] b_data_s;
    wire a_ovr_s;
    wire b_ovr_s;

    amc_sync #(.W(SW)) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .d({sample_clk, extended_control_select_n, interleave_select, single_bus_select,
            output_phase_select, chan_a_shutdown, chan_b_shutdown, calibration_running,
            conv_a_ovr, conv_b_ovr, conv_a_data, conv_b_data}),
        .q(pins_s)
    );

    assign {smp_clk_s, ecm_n_s, il_pin_s, single_bus_s, phase_pin_s, pd_a_pin_s, pd_b_pin_s,
            cal_s, a_ovr_s, b_ovr_s, a_data_s, b_data_s} = pins_s;

    // ============================================================
    // sampling clock edges
    reg smp_clk_d;
    wire smp_rise = smp_clk_s & ~smp_clk_d;
    wire smp_fall = ~smp_clk_s & smp_clk_d;

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            smp_clk_d <= 1'b0;
        end else begin
            smp_clk_d <= smp_clk_s;
        end
    end

    // ============================================================
    // control registers
    reg [15:0] config_reg;
    reg [15:0] extclk_reg;
    reg rate_reg;
    wire register_control_mode = ~ecm_n_s;

    // ============================================================
    // effective mode decode
    wire split_mode = register_control_mode & extclk_reg[`AMC_EXT_SPLIT_BIT];
    // pin picks interleaving in pin mode
    wire il_mode = (register_control_mode ? config_reg[`AMC_CFG_IL_BIT] : il_pin_s) | split_mode;
    // demux only from its own pin, low = demux
    wire demux = ~single_bus_s;
    wire phase_sel = register_control_mode ? config_reg[`AMC_CFG_PHASE_BIT] : phase_pin_s;
    // non-demux forces DDR at zero phase
    wire sdr_mode = demux & register_control_mode & rate_reg;
    wire phase_eff = demux & phase_sel;
    // either source shuts a channel down
    wire pd_a = pd_a_pin_s | (register_control_mode & config_reg[`AMC_CFG_PD_A_BIT]);
    wire pd_b = pd_b_pin_s | (register_control_mode & config_reg[`AMC_CFG_PD_B_BIT]);
    // dual inputs from the dual bit or split mode, register mode only
    wire dual_in = register_control_mode & (config_reg[`AMC_CFG_DUAL_BIT] | split_mode);
    // B select routes input B to both converters when interleaving without dual
    wire in_b_sel = register_control_mode & config_reg[`AMC_CFG_INB_BIT];

    // mode outputs registered
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            chan_a_powerdown <= 1'b0;
            chan_b_powerdown <= 1'b0;
            interleave_active <= 1'b0;
            conv_a_uses_input_b <= 1'b0;
            conv_b_uses_input_b <= 1'b0;
            split_path_interleave_mode <= 1'b0;
        end else begin
            chan_a_powerdown <= pd_a;
            chan_b_powerdown <= pd_b;
            interleave_active <= il_mode;
            conv_a_uses_input_b <= il_mode & ~dual_in & in_b_sel;
            conv_b_uses_input_b <= il_mode ? (dual_in | in_b_sel) : 1'b1;
            // separate paths sampled half a period apart
            split_path_interleave_mode <= split_mode;
        end
    end

    // ============================================================
    // calibration blanking and pipeline flush
    reg [5:0] flush_cnt;
    wire out_valid = ~cal_s & (flush_cnt == 6'd0);

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flush_cnt <= `AMC_FLUSH_CYCLES;
        end else if (cal_s) begin
            flush_cnt <= `AMC_FLUSH_CYCLES;
        end else if (smp_rise && flush_cnt != 6'd0) begin
            flush_cnt <= flush_cnt - 6'd1;
        end
    end

    // ============================================================
    // sample capture and bus ordering
    reg half;
    reg [DW-1:0] b_fall_reg;
    reg b_fall_ovr;
    reg [DW-1:0] a_early;
    reg [DW-1:0] b_early;
    reg ovr_a_early;
    reg ovr_b_early;
    wire update = smp_rise & (~demux | half);
    wire mid = demux ? (smp_rise & ~half) : smp_fall;
    // interleave takes B from the falling edge
    wire [DW-1:0] b_now = il_mode ? b_fall_reg : b_data_s;
    wire b_now_ovr = il_mode ? b_fall_ovr : b_ovr_s;
    wire keep_a = out_valid & ~pd_a;
    wire keep_b = out_valid & ~pd_b;

    // B converter word captured on the falling sampling edge
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            b_fall_reg <= {DW{1'b0}};
            b_fall_ovr <= 1'b0;
        end else if (smp_fall) begin
            b_fall_reg <= b_data_s;
            b_fall_ovr <= b_ovr_s;
        end
    end

    // demux early half, then the group at update
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            half <= 1'b0;
            a_early <= {DW{1'b0}};
            b_early <= {DW{1'b0}};
            ovr_a_early <= 1'b0;
            ovr_b_early <= 1'b0;
            bus_a_main <= {DW{1'b0}};
            bus_a_delayed <= {DW{1'b0}};
            bus_b_main <= {DW{1'b0}};
            bus_b_delayed <= {DW{1'b0}};
            ovr_a <= 1'b0;
            ovr_b <= 1'b0;
        end else begin
            if (smp_rise) begin
                half <= demux ? ~half : 1'b0;
            end
            if (smp_rise && demux && !half) begin
                a_early <= a_data_s;
                b_early <= b_now;
                ovr_a_early <= a_ovr_s;
                ovr_b_early <= b_now_ovr;
            end
            // blank buses and over-range while calibrating or flushing
            if (!out_valid) begin
                bus_a_main <= {DW{1'b0}};
                bus_a_delayed <= {DW{1'b0}};
                bus_b_main <= {DW{1'b0}};
                bus_b_delayed <= {DW{1'b0}};
                ovr_a <= 1'b0;
                ovr_b <= 1'b0;
            end else if (update) begin
                // later pair on main buses, earlier pair on delayed
                // in interleave the B bus carries the earlier word of the pair
                bus_a_main <= keep_a ? a_data_s : {DW{1'b0}};
                bus_b_main <= keep_b ? b_now : {DW{1'b0}};
                // single bus per channel without demux
                // delayed buses only carry data in demux
                bus_a_delayed <= (keep_a & demux) ? a_early : {DW{1'b0}};
                bus_b_delayed <= (keep_b & demux) ? b_early : {DW{1'b0}};
                ovr_a <= keep_a & (a_ovr_s | (demux & ovr_a_early));
                ovr_b <= keep_b & (b_now_ovr | (demux & ovr_b_early));
            end
        end
    end

    // ============================================================
    // forwarded output clock, never blanked
    // clock runs on regardless of calibration
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            forwarded_output_clock <= 1'b0;
        end else if (sdr_mode) begin
            // phase high gives rising edge at update, low falling
            if (update) begin
                forwarded_output_clock <= phase_eff;
            end else if (mid) begin
                forwarded_output_clock <= ~phase_eff;
            end
        end else if (phase_eff ? mid : update) begin
            // zero phase toggles with data, ninety toggles midway
            forwarded_output_clock <= ~forwarded_output_clock;
        end
    end

    // ============================================================
    // axi4-lite write channel
    reg aw_full;
    reg w_full;
    reg [`AMC_ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire wr_go = aw_full & w_full & ~s_axi_bvalid;
    wire wr_hit = (aw_addr == `AMC_ADDR_CONFIG) | (aw_addr == `AMC_ADDR_EXTCLK) |
                  (aw_addr == `AMC_ADDR_STATUS) | (aw_addr == `AMC_ADDR_RATE);
    wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

    // aw and w in either order, one write at a time
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= {`AMC_ADDR_W{1'b0}};
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AMC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `AMC_RESP_OKAY : `AMC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // register storage
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            config_reg <= `AMC_CONFIG_DEFAULT;
            extclk_reg <= `AMC_EXTCLK_DEFAULT;
            rate_reg <= `AMC_RATE_DEFAULT;
        end else if (!register_control_mode) begin
            // pin mode holds every register at its default
            // writes have no effect in pin mode
            config_reg <= `AMC_CONFIG_DEFAULT;
            extclk_reg <= `AMC_EXTCLK_DEFAULT;
            rate_reg <= `AMC_RATE_DEFAULT;
        end else if (wr_go) begin
            if (aw_addr == `AMC_ADDR_CONFIG) begin
                config_reg <= (config_reg & ~wmask) | (w_data[15:0] & wmask);
            end
            if (aw_addr == `AMC_ADDR_EXTCLK) begin
                extclk_reg <= (extclk_reg & ~wmask) | (w_data[15:0] & wmask);
            end
            if (aw_addr == `AMC_ADDR_RATE && w_strb[0]) begin
                rate_reg <= w_data[`AMC_RATE_SDR_BIT];
            end
        end
    end

    // ============================================================
    // axi4-lite read channel
    reg [31:0] rd_mux;
    reg rd_hit;

    // status word shows the live effective mode
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `AMC_ADDR_CONFIG: rd_mux[15:0] = config_reg;
            `AMC_ADDR_EXTCLK: rd_mux[15:0] = extclk_reg;
            `AMC_ADDR_RATE: rd_mux[`AMC_RATE_SDR_BIT] = rate_reg;
            `AMC_ADDR_STATUS: begin
                rd_mux[`AMC_ST_ECM] = register_control_mode;
                rd_mux[`AMC_ST_IL] = il_mode;
                rd_mux[`AMC_ST_DEMUX] = demux;
                rd_mux[`AMC_ST_PHASE] = phase_eff;
                rd_mux[`AMC_ST_SDR] = sdr_mode;
                rd_mux[`AMC_ST_PD_A] = pd_a;
                rd_mux[`AMC_ST_PD_B] = pd_b;
                rd_mux[`AMC_ST_CAL] = cal_s;
                rd_mux[`AMC_ST_VALID] = out_valid;
                rd_mux[`AMC_ST_SPLIT] = split_mode;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // one read at a time, answer one cycle after the address
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AMC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `AMC_RESP_OKAY : `AMC_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // amc_top

//--- pkg/amc_consts.vh
`ifndef AMC_CONSTS_VH
`define AMC_CONSTS_VH

// ============================================================
// register indices and byte addresses
`define AMC_IDX_CONFIG 8'h00
`define AMC_IDX_EXTCLK 8'h0e
`define AMC_IDX_STATUS 8'h10
`define AMC_IDX_RATE 8'h11
`define AMC_ADDR_CONFIG 8'h00
`define AMC_ADDR_EXTCLK 8'h38
`define AMC_ADDR_STATUS 8'h40
`define AMC_ADDR_RATE 8'h44
`define AMC_ADDR_W 8

// ============================================================
// configuration, extended clock and rate register fields
`define AMC_CFG_PHASE_BIT 14
`define AMC_CFG_PD_A_BIT 11
`define AMC_CFG_PD_B_BIT 10
`define AMC_CFG_IL_BIT 7
`define AMC_CFG_INB_BIT 6
`define AMC_CFG_DUAL_BIT 5
`define AMC_EXT_SPLIT_BIT 6
`define AMC_RATE_SDR_BIT 0

// ============================================================
// reset values
`define AMC_CONFIG_DEFAULT 16'h0000
`define AMC_EXTCLK_DEFAULT 16'h0000
`define AMC_RATE_DEFAULT 1'b0

// ============================================================
// status register fields
`define AMC_ST_ECM 0
`define AMC_ST_IL 1
`define AMC_ST_DEMUX 2
`define AMC_ST_PHASE 3
`define AMC_ST_SDR 4
`define AMC_ST_PD_A 5
`define AMC_ST_PD_B 6
`define AMC_ST_CAL 7
`define AMC_ST_VALID 8
`define AMC_ST_SPLIT 9

// ============================================================
// timing and bus answers
`define AMC_FLUSH_CYCLES 6'd60
`define AMC_RESP_OKAY 2'b00
`define AMC_RESP_SLVERR 2'b10

`endif

//--- testbench/amc_far_end.sv
// ============================================================
// capture model of the receiving logic
module amc_far_end #(
    parameter DW = 12
) (
    input logic core_clk,
    input logic forwarded_output_clock,
    input logic [DW-1:0] bus_a_main,
    input logic [DW-1:0] bus_a_delayed,
    input logic [DW-1:0] bus_b_main,
    input logic [DW-1:0] bus_b_delayed,
    output logic [DW-1:0] cap [4],
    output int edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fck_d_reg = 1'b0;
    // ddr capture on either edge, earliest word first
    always @(posedge core_clk) begin
        fck_d_reg <= forwarded_output_clock;
        if (forwarded_output_clock !== fck_d_reg) begin
            cap <= '{bus_b_delayed, bus_a_delayed, bus_b_main, bus_a_main};
            edges <= edges + 1;
        end
    end
endmodule // amc_far_end

//--- testbench/amc_props.sv
// ============================================================
// mode and output checks on the top ports
module amc_props #(
    parameter DW = 12
) (
    input wire core_clk,
    input wire resetn,
    input wire sample_clk,
    input wire extended_control_select_n,
    input wire interleave_select,
    input wire single_bus_select,
    input wire chan_a_shutdown,
    input wire chan_b_shutdown,
    input wire calibration_running,
    input wire [DW-1:0] bus_a_main,
    input wire [DW-1:0] bus_a_delayed,
    input wire [DW-1:0] bus_b_main,
    input wire [DW-1:0] bus_b_delayed,
    input wire ovr_a,
    input wire ovr_b,
    input wire forwarded_output_clock,
    input wire chan_a_powerdown,
    input wire chan_b_powerdown,
    input wire interleave_active,
    input wire conv_a_uses_input_b,
    input wire conv_b_uses_input_b,
    input wire split_path_interleave_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_d_reg, fck_d_reg;
    logic [5:0] flush_reg, stall_reg, mono_reg;
    wire all_low = ~|{bus_a_main, bus_a_delayed, bus_b_main, bus_b_delayed, ovr_a, ovr_b};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // raw rise, clock-idle and single-bus counters; flush bound keeps slack
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_d_reg <= 1'b0;
            fck_d_reg <= 1'b0;
            flush_reg <= 6'h3f;
            stall_reg <= 6'h00;
            mono_reg <= 6'h00;
        end else begin
            sclk_d_reg <= sample_clk;
            fck_d_reg <= forwarded_output_clock;
            if (calibration_running)
                flush_reg <= 6'h00;
            else if (sample_clk && !sclk_d_reg && flush_reg != 6'h3f)
                flush_reg <= flush_reg + 6'h01;
            stall_reg <= (forwarded_output_clock != fck_d_reg) ? 6'h00 : stall_reg + {5'h00, stall_reg != 6'h3f};
            mono_reg <= single_bus_select ? mono_reg + {5'h00, mono_reg != 6'h3f} : 6'h00;
        end
    end
    sequence cal_held_s;
        calibration_running [*5];
    endsequence
    sequence pin_mode_s;
        extended_control_select_n [*5];
    endsequence
    // sync flops and output register delay pins
    cal_blank_a: assert property (cal_held_s |-> all_low) else $error("outputs live in calibration");
    clk_runs_a: assert property (calibration_running |-> stall_reg < 6'd60) else $error("clock stalled");
    flush_hold_a: assert property (flush_reg != 6'h00 && flush_reg < 6'd58 |-> all_low)
        else $error("outputs live during flush");
    shut_a_a: assert property (chan_a_shutdown [*5] |-> chan_a_powerdown) else $error("channel a up");
    shut_b_a: assert property (chan_b_shutdown [*5] |-> chan_b_powerdown) else $error("channel b up");
    pin_input_a: assert property (pin_mode_s ##0 interleave_active |-> !conv_a_uses_input_b &&
        !conv_b_uses_input_b) else $error("pin interleave not on input a");
    pin_select_a: assert property ((extended_control_select_n && $stable(interleave_select)) [*5] |->
        interleave_active == interleave_select) else $error("interleave does not follow pin");
    split_path_a: assert property (split_path_interleave_mode |-> interleave_active &&
        !conv_a_uses_input_b && conv_b_uses_input_b) else $error("split mode paths wrong");
    one_bus_a: assert property (mono_reg > 6'd40 |-> bus_a_delayed == '0 && bus_b_delayed == '0)
        else $error("delayed bus active in single-bus mode");
endmodule // amc_props

bind amc_top amc_props #(.DW(DW)) u_props (.*);

//--- testbench/testbench.sv
`include "amc_consts.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("Error at %0t: got %h, exp %h", $time, (a), (e)); end end
// ============================================================
// mode and output-order bench
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DW = 12;
    logic core_clk, resetn, sample_clk, extended_control_select_n, interleave_select, single_bus_select;
    logic output_phase_select, chan_a_shutdown, chan_b_shutdown, calibration_running, conv_a_ovr, conv_b_ovr;
    logic ovr_a, ovr_b, forwarded_output_clock, chan_a_powerdown, chan_b_powerdown, interleave_active;
    logic conv_a_uses_input_b, conv_b_uses_input_b, split_path_interleave_mode;
    logic [DW-1:0] conv_a_data, conv_b_data, bus_a_main, bus_a_delayed, bus_b_main, bus_b_delayed, word;
    logic [DW-1:0] cap [4];
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, sc_hist;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int edges, mismatches, tests_run, cycles, e0;
    amc_top #(.DW(DW)) dut (.*);
    amc_far_end #(.DW(DW)) far_end (.*);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // sampling clock, phase unrelated to the core clock
    initial begin
        sample_clk = 1'b0;
        #7.3;
        forever #24 sample_clk = ~sample_clk;
    end
    // words step after each sampling edge; b is the inverse of a
    always @(posedge core_clk) begin
        sc_hist <= {sc_hist[2:0], sample_clk};
        if (sc_hist[3] != sc_hist[2]) begin
            word <= word + 12'h001;
            conv_a_data <= word + 12'h001;
            conv_b_data <= ~(word + 12'h001);
            conv_a_ovr <= (word[2:0] == 3'h6);
            conv_b_ovr <= (word[2:0] == 3'h2);
        end
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            finish_test;
        end
    end
    task automatic finish_test;
        begin
            $display("mismatches %0d, checks %0d", mismatches, tests_run);
            if (mismatches == 0 && tests_run > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // ============================================================
    // bus access: valid held until ready
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hf;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge core_clk);
                if (s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            s_axi_bready <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task automatic axr(input logic [7:0] a);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(posedge core_clk);
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
            end while (s_axi_rvalid !== 1'b1);
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    // waits for a clock edge, then one more
    task automatic grab;
        begin
            e0 = edges;
            while (edges == e0)
                @(posedge core_clk);
            @(posedge core_clk);
        end
    endtask
    // ============================================================
    // main sequence
    initial begin
        resetn = 1'b0;
        {extended_control_select_n, interleave_select, single_bus_select, output_phase_select} = 4'b1010;
        {chan_a_shutdown, chan_b_shutdown, calibration_running} = 3'b000;
        {word, conv_a_data, conv_b_data, conv_a_ovr, conv_b_ovr, sc_hist} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        tick(8);
        resetn <= 1'b1;
        tick(700);
        grab;
        `CHK(cap[2], ~cap[3])
        `CHK(cap[1], 12'h000)
        axw(`AMC_ADDR_CONFIG, 32'h0000_0080);
        tick(10);
        `CHK(interleave_active, 1'b0)
        axr(`AMC_ADDR_CONFIG);
        `CHK(rd, 32'h0000_0000)
        `CHK(rsp, `AMC_RESP_OKAY)
        calibration_running <= 1'b1;
        tick(20);
        `CHK({bus_a_main, ovr_a, ovr_b}, 14'h0000)
        e0 = edges;
        tick(100);
        `CHK(edges > e0, 1'b1)
        calibration_running <= 1'b0;
        tick(300);
        `CHK(bus_b_main, 12'h000)
        tick(400);
        grab;
        `CHK(cap[3] != 12'h000, 1'b1)
        `CHK(cap[2], ~cap[3])
        chan_a_shutdown <= 1'b1;
        tick(40);
        `CHK(chan_a_powerdown, 1'b1)
        `CHK(bus_a_main, 12'h000)
        chan_a_shutdown <= 1'b0;
        interleave_select <= 1'b1;
        tick(100);
        grab;
        `CHK({interleave_active, conv_a_uses_input_b, conv_b_uses_input_b}, 3'b100)
        `CHK(cap[2], ~(cap[3] - 12'h001))
        single_bus_select <= 1'b0;
        tick(100);
        grab;
        `CHK(cap[1], ~cap[0] + 12'h001)
        `CHK(cap[2], ~(cap[1] + 12'h001))
        `CHK(cap[3], ~cap[2] + 12'h001)
        interleave_select <= 1'b0;
        tick(100);
        grab;
        `CHK(cap[3], cap[1] + 12'h002)
        `CHK(cap[2], ~cap[3])
        single_bus_select <= 1'b1;
        extended_control_select_n <= 1'b0;
        tick(10);
        axw(`AMC_ADDR_CONFIG, 32'h0000_0080);
        tick(10);
        `CHK(interleave_active, 1'b1)
        axw(`AMC_ADDR_CONFIG, 32'h0000_00c0);
        tick(10);
        `CHK({conv_a_uses_input_b, conv_b_uses_input_b}, 2'b11)
        axw(`AMC_ADDR_CONFIG, 32'h0000_00a0);
        tick(10);
        `CHK({conv_a_uses_input_b, conv_b_uses_input_b}, 2'b01)
        axw(`AMC_ADDR_EXTCLK, 32'h0000_0040);
        tick(10);
        `CHK(split_path_interleave_mode, 1'b1)
        // interleave off before a channel goes down
        axw(`AMC_ADDR_EXTCLK, 32'h0000_0000);
        axw(`AMC_ADDR_CONFIG, 32'h0000_4800);
        axw(`AMC_ADDR_RATE, 32'h0000_0001);
        chan_b_shutdown <= 1'b1;
        single_bus_select <= 1'b0;
        tick(40);
        `CHK({chan_a_powerdown, chan_b_powerdown}, 2'b11)
        axr(`AMC_ADDR_STATUS);
        `CHK(rd[4:0], 5'b11101)
        axr(`AMC_ADDR_CONFIG);
        `CHK(rd, 32'h0000_4800)
        axr(8'h80);
        `CHK(rsp, `AMC_RESP_SLVERR)
        extended_control_select_n <= 1'b1;
        chan_b_shutdown <= 1'b0;
        tick(10);
        axr(`AMC_ADDR_CONFIG);
        `CHK(rd, 32'h0000_0000)
        `CHK(chan_a_powerdown, 1'b0)
        finish_test;
    end
endmodule // testbench
